// ==== gpm_pkg.sv ====
// constants, offsets and types for the gpio ports with pin mux
// Overview of operation
// - select bits 6,5: 0 gives B7,B6 to flash ready/busy, 1 to gpio
// - select bits 4..1: 0 gives B5..B2 to flash strobes, 1 to gpio
// - select bit 0: 0 gives port D to parallel data bus, 1 to gpio
// - drive enable bit 1 enables that pin's output driver; resets 0
// - sense enable bit 1 enables that pin's input path; resets 0
// - level register drives enabled pins and reads back sensed pin levels, else the stored level
// - port E has pins 4..0 only; upper sense and level bits reserved
// - port E drive bits 7:6: 10 slow oscillator, 11 fast oscillator out
// - port E drive bit 7 set makes E4 an oscillator output only
// - PWM enabled puts PWM on C0, otherwise C0 goes back to emulator port or gpio per select bit 7
// - select bit 7: 0 gives A1,A3,A4,C0,C1 to emulator port; resets 0
// - each of 45 pins may drive and sense at the same time
package gpm_pkg;
    localparam int ADDR_W = 12;
    localparam int NUM_PORTS = 6;
    localparam int NUM_PADS = 48;
    // printed offsets are register indices; byte address is index times four
    localparam logic [7:0] IDX_A_DRIVE = 8'hed;
    localparam logic [7:0] IDX_PIN_FN = 8'hee;
    localparam logic [7:0] IDX_A_SENSE = 8'hef;
    localparam logic [7:0] IDX_A_LEVELS = 8'hf0;
    localparam logic [7:0] IDX_B_DRIVE = 8'hf1;
    localparam logic [7:0] IDX_B_SENSE = 8'hf2;
    localparam logic [7:0] IDX_B_LEVELS = 8'hf3;
    localparam logic [7:0] IDX_C_DRIVE = 8'hf4;
    localparam logic [7:0] IDX_C_SENSE = 8'hf5;
    localparam logic [7:0] IDX_C_LEVELS = 8'hf6;
    localparam logic [7:0] IDX_D_DRIVE = 8'hf7;
    localparam logic [7:0] IDX_D_SENSE = 8'hf8;
    localparam logic [7:0] IDX_D_LEVELS = 8'hf9;
    localparam logic [7:0] IDX_E_DRIVE = 8'hfa;
    localparam logic [7:0] IDX_E_SENSE = 8'hfb;
    localparam logic [7:0] IDX_E_LEVELS = 8'hfc;
    localparam logic [7:0] IDX_F_DRIVE = 8'hfd;
    localparam logic [7:0] IDX_F_SENSE = 8'hfe;
    localparam logic [7:0] IDX_F_LEVELS = 8'hff;
    localparam logic [7:0] RST_ENABLES = 8'h00;
    localparam logic [7:0] RST_PIN_FN = 8'h00;
    localparam logic [7:0] RST_LEVELS = 8'h00;
    localparam logic [7:0] PORT_E_MASK = 8'h1f;
    localparam logic [7:0] FULL_MASK = 8'hff;
    localparam logic [2:0] PORT_E = 3'h4;
    // pin function select fields
    localparam int PFS_DEBUG = 7;
    localparam int PFS_RB_SECOND = 6;
    localparam int PFS_RB_FIRST = 5;
    localparam int PFS_CMD = 4;
    localparam int PFS_ADDR = 3;
    localparam int PFS_WR = 2;
    localparam int PFS_RD = 1;
    localparam int PFS_DATA = 0;
    localparam int OSC_ENABLE_BIT = 7;
    localparam int OSC_FAST_BIT = 6;
    // flat pad index = port * 8 + pin
    localparam int DBG_PIN [5] = '{1, 3, 4, 16, 17};
    localparam int PIN_RB_SECOND = 15;
    localparam int PIN_RB_FIRST = 14;
    localparam int PIN_CMD = 13;
    localparam int PIN_ADDR = 12;
    localparam int PIN_WR = 11;
    localparam int PIN_RD = 10;
    localparam int PIN_DATA_BASE = 24;
    localparam int PIN_OSC = 36;
    localparam int PIN_PWM = 16;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        KIND_DRIVE  = 2'b00,
        KIND_SENSE  = 2'b01,
        KIND_LEVELS = 2'b10,
        KIND_PIN_FN = 2'b11
    } gpm_kind_t;

    typedef struct packed {
        logic      hit;
        logic [2:0] port;
        gpm_kind_t kind;
    } gpm_sel_t;
endpackage

// ==== gpm_gpio_mux.sv ====
// six gpio ports with pin function mux behind an axi4-lite slave
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module gpm_gpio_mux (
    input  wire logic                          clock,       // 25 MHz system clock
    input  wire logic                          resetn,      // async reset, active low
    input  wire logic                          ce,          // clock enable, freezes all
    input  wire logic [gpm_pkg::ADDR_W-1:0]    awaddr,      // write address
    input  wire logic                          awvalid,     // write address valid
    output logic                               awready,     // write address ready
    input  wire logic [31:0]                   wdata,       // write data
    input  wire logic [3:0]                    wstrb,       // write byte strobes
    input  wire logic                          wvalid,      // write data valid
    output logic                               wready,      // write data ready
    output logic [1:0]                         bresp,       // write response
    output logic                               bvalid,      // write response valid
    input  wire logic                          bready,      // write response ready
    input  wire logic [gpm_pkg::ADDR_W-1:0]    araddr,      // read address
    input  wire logic                          arvalid,     // read address valid
    output logic                               arready,     // read address ready
    output logic [31:0]                        rdata,       // read data
    output logic [1:0]                         rresp,       // read response
    output logic                               rvalid,      // read data valid
    input  wire logic                          rready,      // read data ready
    input  wire logic [7:0]                    padAIn,      // port A pad levels
    output logic [7:0]                         padAOut,     // port A pad drive level
    output logic [7:0]                         padAOe,      // port A pad drive enable
    input  wire logic [7:0]                    padBIn,      // port B pad levels
    output logic [7:0]                         padBOut,     // port B pad drive level
    output logic [7:0]                         padBOe,      // port B pad drive enable
    input  wire logic [7:0]                    padCIn,      // port C pad levels
    output logic [7:0]                         padCOut,     // port C pad drive level
    output logic [7:0]                         padCOe,      // port C pad drive enable
    input  wire logic [7:0]                    padDIn,      // port D pad levels
    output logic [7:0]                         padDOut,     // port D pad drive level
    output logic [7:0]                         padDOe,      // port D pad drive enable
    input  wire logic [4:0]                    padEIn,      // port E pad levels
    output logic [4:0]                         padEOut,     // port E pad drive level
    output logic [4:0]                         padEOe,      // port E pad drive enable
    input  wire logic [7:0]                    padFIn,      // port F pad levels
    output logic [7:0]                         padFOut,     // port F pad drive level
    output logic [7:0]                         padFOe,      // port F pad drive enable
    output logic                               flashReadyBusyFirstN,  // from pad B6
    output logic                               flashReadyBusySecondN, // from pad B7
    input  wire logic                          commandLatch,          // to pad B5
    input  wire logic                          addressLatch,          // to pad B4
    input  wire logic                          memoryWriteStrobeN,    // to pad B3
    input  wire logic                          memoryReadStrobeN,     // to pad B2
    input  wire logic [7:0]                    dataBusOut,  // parallel bus drive level
    input  wire logic                          dataBusOe,   // parallel bus drive enable
    output logic [7:0]                         dataBusIn,   // parallel bus levels
    input  wire logic [4:0]                    debugOut,    // emulator port drive level
    input  wire logic [4:0]                    debugOe,     // emulator port drive enable
    output logic [4:0]                         debugIn,     // emulator port levels
    input  wire logic                          pwmEnable,   // pwm controller enabled
    input  wire logic                          pwmOut,      // pwm waveform
    input  wire logic                          slowOscillatorClock, // slow osc level
    input  wire logic                          fastOscillatorClock  // fast osc level
);

    logic [7:0] driveEn_r [gpm_pkg::NUM_PORTS];
    logic [7:0] senseEn_r [gpm_pkg::NUM_PORTS];
    logic [7:0] levels_r [gpm_pkg::NUM_PORTS];
    logic [7:0] pinFnSel_r;
    logic       awready_r;
    logic       wready_r;
    logic       bvalid_r;
    logic [1:0] bresp_r;
    logic       arready_r;
    logic       rvalid_r;
    logic [7:0] rdata_r;
    logic [1:0] rresp_r;
    logic [gpm_pkg::NUM_PADS-1:0] padOut_r;
    logic [gpm_pkg::NUM_PADS-1:0] padOe_r;
    logic [gpm_pkg::NUM_PADS-1:0] padOut_nxt;
    logic [gpm_pkg::NUM_PADS-1:0] padOe_nxt;
    logic [gpm_pkg::NUM_PADS-1:0] gpioOut;
    logic [gpm_pkg::NUM_PADS-1:0] gpioOe;
    logic [gpm_pkg::NUM_PADS-1:0] padIn;
    logic       rbFirst_r;
    logic       rbSecond_r;
    logic [7:0] dataBusIn_r;
    logic [4:0] debugIn_r;
    logic [7:0] rdValue;

    // index decode, shared by the read and write paths
    function automatic gpm_pkg::gpm_sel_t decodeIdx(input logic [gpm_pkg::ADDR_W-1:0] addr);
        gpm_pkg::gpm_sel_t s;
        s.hit = (addr[11:10] == 2'h0) && (addr[1:0] == 2'h0);
        s.port = 3'h0;
        s.kind = gpm_pkg::KIND_DRIVE;
        case (addr[9:2])
            gpm_pkg::IDX_A_DRIVE:  s.port = 3'h0;
            gpm_pkg::IDX_A_SENSE:  s.kind = gpm_pkg::KIND_SENSE;
            gpm_pkg::IDX_A_LEVELS: s.kind = gpm_pkg::KIND_LEVELS;
            gpm_pkg::IDX_PIN_FN:   s.kind = gpm_pkg::KIND_PIN_FN;
            gpm_pkg::IDX_B_DRIVE:  s.port = 3'h1;
            gpm_pkg::IDX_B_SENSE:  {s.port, s.kind} = {3'h1, gpm_pkg::KIND_SENSE};
            gpm_pkg::IDX_B_LEVELS: {s.port, s.kind} = {3'h1, gpm_pkg::KIND_LEVELS};
            gpm_pkg::IDX_C_DRIVE:  s.port = 3'h2;
            gpm_pkg::IDX_C_SENSE:  {s.port, s.kind} = {3'h2, gpm_pkg::KIND_SENSE};
            gpm_pkg::IDX_C_LEVELS: {s.port, s.kind} = {3'h2, gpm_pkg::KIND_LEVELS};
            gpm_pkg::IDX_D_DRIVE:  s.port = 3'h3;
            gpm_pkg::IDX_D_SENSE:  {s.port, s.kind} = {3'h3, gpm_pkg::KIND_SENSE};
            gpm_pkg::IDX_D_LEVELS: {s.port, s.kind} = {3'h3, gpm_pkg::KIND_LEVELS};
            gpm_pkg::IDX_E_DRIVE:  s.port = 3'h4;
            gpm_pkg::IDX_E_SENSE:  {s.port, s.kind} = {3'h4, gpm_pkg::KIND_SENSE};
            gpm_pkg::IDX_E_LEVELS: {s.port, s.kind} = {3'h4, gpm_pkg::KIND_LEVELS};
            gpm_pkg::IDX_F_DRIVE:  s.port = 3'h5;
            gpm_pkg::IDX_F_SENSE:  {s.port, s.kind} = {3'h5, gpm_pkg::KIND_SENSE};
            gpm_pkg::IDX_F_LEVELS: {s.port, s.kind} = {3'h5, gpm_pkg::KIND_LEVELS};
            default:               s.hit = 1'b0;
        endcase
        return s;
    endfunction

    // pin mask of a port: port E has five pins
    function automatic logic [7:0] portMask(input logic [2:0] port);
        return (port == gpm_pkg::PORT_E) ? gpm_pkg::PORT_E_MASK : gpm_pkg::FULL_MASK;
    endfunction

    wire gpm_pkg::gpm_sel_t wrSel = decodeIdx(awaddr);
    wire gpm_pkg::gpm_sel_t rdSel = decodeIdx(araddr);
    wire wrFire = awvalid && awready_r && wvalid && wready_r;
    wire rdFire = arvalid && arready_r;
    wire wrStart = awvalid && wvalid && !awready_r && !bvalid_r;
    wire rdStart = arvalid && !arready_r && !rvalid_r;
    wire wrLow = wrFire && wrSel.hit && wstrb[0];
    wire [7:0] wrByte = wdata[7:0] & portMask(wrSel.port);
    wire [7:0] rdPads = padIn[{rdSel.port, 3'h0} +: 8];
    wire [3:0] flashStrobes = {commandLatch, addressLatch, memoryWriteStrobeN, memoryReadStrobeN};

    assign padIn = {padFIn, 3'h0, padEIn, padDIn, padCIn, padBIn, padAIn};

    // ordinary gpio drive, independent of the sense enables
    generate
        for (genvar p = 0; p < gpm_pkg::NUM_PORTS; p++)
        begin : g_port
            assign gpioOut[p*8 +: 8] = levels_r[p];
            assign gpioOe[p*8 +: 8] = driveEn_r[p] & portMask(3'(p));
        end
    endgenerate

    // alternate functions take over pads; pwm wins over the emulator on C0
    always_comb
    begin
        padOut_nxt = gpioOut;
        padOe_nxt = gpioOe;
        if (!pinFnSel_r[gpm_pkg::PFS_DEBUG])
        begin
            for (int j = 0; j < 5; j++)
            begin
                padOut_nxt[gpm_pkg::DBG_PIN[j]] = debugOut[j];
                padOe_nxt[gpm_pkg::DBG_PIN[j]] = debugOe[j];
            end
        end
        if (!pinFnSel_r[gpm_pkg::PFS_RB_SECOND])
            padOe_nxt[gpm_pkg::PIN_RB_SECOND] = 1'b0;
        if (!pinFnSel_r[gpm_pkg::PFS_RB_FIRST])
            padOe_nxt[gpm_pkg::PIN_RB_FIRST] = 1'b0;
        for (int j = 0; j < 4; j++)
            if (!pinFnSel_r[gpm_pkg::PFS_RD + j])
            begin
                padOut_nxt[gpm_pkg::PIN_RD + j] = flashStrobes[j];
                padOe_nxt[gpm_pkg::PIN_RD + j] = 1'b1;
            end
        if (!pinFnSel_r[gpm_pkg::PFS_DATA])
        begin
            padOut_nxt[gpm_pkg::PIN_DATA_BASE +: 8] = dataBusOut;
            padOe_nxt[gpm_pkg::PIN_DATA_BASE +: 8] = {8{dataBusOe}};
        end
        if (pwmEnable)
        begin
            padOut_nxt[gpm_pkg::PIN_PWM] = pwmOut;
            padOe_nxt[gpm_pkg::PIN_PWM] = 1'b1;
        end
        // 00 and 01 are reserved and leave E4 as gpio
        if (driveEn_r[gpm_pkg::PORT_E][gpm_pkg::OSC_ENABLE_BIT])
        begin
            padOut_nxt[gpm_pkg::PIN_OSC] = driveEn_r[gpm_pkg::PORT_E][gpm_pkg::OSC_FAST_BIT]
                ? fastOscillatorClock : slowOscillatorClock;
            padOe_nxt[gpm_pkg::PIN_OSC] = 1'b1;
        end
    end

    // read mux: sensed pins return the pad, others the stored level
    always_comb
    begin
        rdValue = 8'h00;
        case (rdSel.kind)
            gpm_pkg::KIND_DRIVE:  rdValue = driveEn_r[rdSel.port];
            gpm_pkg::KIND_SENSE:  rdValue = senseEn_r[rdSel.port] & portMask(rdSel.port);
            gpm_pkg::KIND_LEVELS: rdValue = ((senseEn_r[rdSel.port] & rdPads)
                | (~senseEn_r[rdSel.port] & levels_r[rdSel.port]))
                & portMask(rdSel.port);
            gpm_pkg::KIND_PIN_FN: rdValue = pinFnSel_r;
            default:              rdValue = 8'h00;
        endcase
    end

    // register file
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            for (int p = 0; p < gpm_pkg::NUM_PORTS; p++)
            begin
                driveEn_r[p] <= gpm_pkg::RST_ENABLES;
                senseEn_r[p] <= gpm_pkg::RST_ENABLES;
                levels_r[p] <= gpm_pkg::RST_LEVELS;
            end
            pinFnSel_r <= gpm_pkg::RST_PIN_FN;
        end
        else if (ce && wrLow)
        begin
            case (wrSel.kind)
                gpm_pkg::KIND_DRIVE:  driveEn_r[wrSel.port] <= wdata[7:0];
                gpm_pkg::KIND_SENSE:  senseEn_r[wrSel.port] <= wrByte;
                gpm_pkg::KIND_LEVELS: levels_r[wrSel.port] <= wrByte;
                gpm_pkg::KIND_PIN_FN: pinFnSel_r <= wdata[7:0];
                default:              pinFnSel_r <= pinFnSel_r;
            endcase
        end
    end

    // write channel: take address and data together, then respond
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= gpm_pkg::RESP_OKAY;
        end
        else if (ce)
        begin
            awready_r <= wrStart;
            wready_r <= wrStart;
            if (wrFire)
            begin
                bvalid_r <= 1'b1;
                bresp_r <= wrSel.hit ? gpm_pkg::RESP_OKAY : gpm_pkg::RESP_SLVERR;
            end
            else if (bready)
                bvalid_r <= 1'b0;
        end
    end

    // read channel
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= 8'h00;
            rresp_r <= gpm_pkg::RESP_OKAY;
        end
        else if (ce)
        begin
            arready_r <= rdStart;
            if (rdFire)
            begin
                rvalid_r <= 1'b1;
                rdata_r <= rdSel.hit ? rdValue : 8'h00;
                rresp_r <= rdSel.hit ? gpm_pkg::RESP_OKAY : gpm_pkg::RESP_SLVERR;
            end
            else if (rready)
                rvalid_r <= 1'b0;
        end
    end

    // pads and alternate inputs are registered so every output is a flop;
    // this costs one cycle, and oscillator clocks are only sampled at 25 MHz
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            padOut_r <= '0;
            padOe_r <= '0;
            rbFirst_r <= 1'b1;
            rbSecond_r <= 1'b1;
            dataBusIn_r <= 8'h00;
            debugIn_r <= 5'h00;
        end
        else if (ce)
        begin
            padOut_r <= padOut_nxt;
            padOe_r <= padOe_nxt;
            rbFirst_r <= padIn[gpm_pkg::PIN_RB_FIRST];
            rbSecond_r <= padIn[gpm_pkg::PIN_RB_SECOND];
            dataBusIn_r <= padIn[gpm_pkg::PIN_DATA_BASE +: 8];
            for (int j = 0; j < 5; j++)
                debugIn_r[j] <= padIn[gpm_pkg::DBG_PIN[j]];
        end
    end

    assign awready = awready_r;
    assign wready = wready_r;
    assign bvalid = bvalid_r;
    assign bresp = bresp_r;
    assign arready = arready_r;
    assign rvalid = rvalid_r;
    assign rdata = {24'h000000, rdata_r};
    assign rresp = rresp_r;
    assign padAOut = padOut_r[7:0];
    assign padAOe = padOe_r[7:0];
    assign padBOut = padOut_r[15:8];
    assign padBOe = padOe_r[15:8];
    assign padCOut = padOut_r[23:16];
    assign padCOe = padOe_r[23:16];
    assign padDOut = padOut_r[31:24];
    assign padDOe = padOe_r[31:24];
    assign padEOut = padOut_r[36:32];
    assign padEOe = padOe_r[36:32];
    assign padFOut = padOut_r[47:40];
    assign padFOe = padOe_r[47:40];
    assign flashReadyBusyFirstN = rbFirst_r;
    assign flashReadyBusySecondN = rbSecond_r;
    assign dataBusIn = dataBusIn_r;
    assign debugIn = debugIn_r;

endmodule // gpm_gpio_mux

// ==== gpm_gpio_mux_asserts.sv ====
// concurrent checks on the gpio mux ports
`timescale 1ns/1ps
module gpm_gpio_mux_asserts (
    input wire logic        clock,                // system clock
    input wire logic        resetn,               // async reset, active low
    input wire logic        awvalid,              // write address valid
    input wire logic        wvalid,               // write data valid
    input wire logic        awready,              // write address ready
    input wire logic        wready,               // write data ready
    input wire logic        bvalid,               // write response valid
    input wire logic        bready,               // write response ready
    input wire logic [1:0]  bresp,                // write response
    input wire logic        arvalid,              // read address valid
    input wire logic        arready,              // read address ready
    input wire logic        rvalid,               // read data valid
    input wire logic        rready,               // read data ready
    input wire logic [31:0] rdata,                // read data
    input wire logic [7:0]  padBIn,               // port B pad levels
    input wire logic [7:0]  padCOut,              // port C drive level
    input wire logic [7:0]  padCOe,               // port C drive enable
    input wire logic [7:0]  padDIn,               // port D pad levels
    input wire logic        pwmEnable,            // pwm enabled
    input wire logic        pwmOut,               // pwm waveform
    input wire logic        flashReadyBusyFirstN, // pad B6 level
    input wire logic [7:0]  dataBusIn             // port D levels
);
    // two live edges first, so $past never sees reset-time pad values
    logic [1:0] upCnt_r;
    always_ff @(posedge clock or negedge resetn)
        if (!resetn) upCnt_r <= 2'h0;
        else upCnt_r <= {upCnt_r[0], 1'b1};
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    sequence s_wreq; awvalid && wvalid && !awready && !bvalid; endsequence
    sequence s_wresp; awready && wready ##1 bvalid; endsequence
    sequence s_rreq; arvalid && !arready && !rvalid; endsequence
    a_write_lat: assert property (s_wreq |=> s_wresp) else $error("write answer late");
    a_read_lat: assert property (s_rreq |=> arready ##1 rvalid) else $error("read late");
    a_aw_pulse: assert property (awready |=> !awready && !wready)
        else $error("ready held");
    a_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped");
    a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped");
    a_rdata_byte: assert property (rvalid |-> rdata[31:8] == 24'h0)
        else $error("wide data");
    a_pwm_owns_c0: assert property (upCnt_r[1] && pwmEnable |=> padCOe[0]
        && padCOut[0] == $past(pwmOut)) else $error("pwm not on C0");
    a_rb_follow: assert property (upCnt_r[1] |-> flashReadyBusyFirstN == $past(padBIn[6]))
        else $error("ready busy not forwarded");
    a_dbus_follow: assert property (upCnt_r[1] |-> dataBusIn == $past(padDIn))
        else $error("data bus not forwarded");
endmodule // gpm_gpio_mux_asserts

bind gpm_gpio_mux gpm_gpio_mux_asserts gpm_gpio_mux_asserts_i (.*);

// ==== gpm_pad_model.sv ====
// outside pads: resolves each pad from device and outside drivers
`timescale 1ns/1ps
module gpm_pad_model #(
    parameter int W = 45
) (
    input  wire logic         clock,  // system clock
    input  wire logic [W-1:0] padOe,  // device drive enable
    input  wire logic [W-1:0] padOut, // device drive level
    input  wire logic [W-1:0] extOe,  // outside drive enable
    input  wire logic [W-1:0] extVal, // outside drive level
    output logic [W-1:0]      level   // resolved pad level
);
    // a floating pad toggles, so a stale level is never mistaken for a read
    logic [W-1:0] held_r = '0;
    always_ff @(posedge clock) held_r <= level;
    always_comb
        for (int i = 0; i < W; i++)
            level[i] = (padOe[i] === 1'b1) ? (extOe[i] ? 1'bx : padOut[i])
                     : (extOe[i] ? extVal[i] : ~held_r[i]);
endmodule // gpm_pad_model

// ==== tb_top.sv ====
// self-checking bench for the gpio ports with pin mux
`timescale 1ns/1ps
module tb_top;
    logic        clock = 0, resetn = 0, ce = 1, awvalid = 0, wvalid = 0, bready = 0;
    logic        arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid;
    logic [11:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic [3:0]  wstrb = 4'hf;
    logic [1:0]  bresp, rresp;
    logic [7:0]  padAIn, padBIn, padCIn, padDIn, padFIn, padAOut, padBOut, padCOut;
    logic [7:0]  padDOut, padFOut, padAOe, padBOe, padCOe, padDOe, padFOe;
    logic [4:0]  padEIn, padEOut, padEOe, debugOut = '0, debugOe = '0, debugIn;
    logic        flashReadyBusyFirstN, flashReadyBusySecondN, dataBusOe = 0;
    logic        commandLatch = 0, addressLatch = 0, memoryWriteStrobeN = 1;
    logic        memoryReadStrobeN = 1, pwmEnable = 0, pwmOut = 0;
    logic        slowOscillatorClock = 0, fastOscillatorClock = 0;
    logic [7:0]  dataBusOut = '0, dataBusIn;
    logic [44:0] extOe = '0, extVal = '0, level;
    int          error_cnt = 0, n_compared = 0;
    wire [44:0]  pOut = {padFOut, padEOut, padDOut, padCOut, padBOut, padAOut};
    wire [44:0]  pOe = {padFOe, padEOe, padDOe, padCOe, padBOe, padAOe};
    assign {padFIn, padEIn, padDIn, padCIn, padBIn, padAIn} = level;
    always #20 clock = ~clock;
    gpm_gpio_mux gpm_gpio_mux_i (.*);
    gpm_pad_model gpm_pad_model_i (.clock, .padOe(pOe), .padOut(pOut), .extOe, .extVal, .level);
    task automatic finish_test;
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [7:0] drv(input int k);
        return (k == 0) ? gpm_pkg::IDX_A_DRIVE : gpm_pkg::IDX_PIN_FN + 8'(3 * k);
    endfunction
    function automatic logic [7:0] sns(input int k);
        return (k == 0) ? gpm_pkg::IDX_A_SENSE : drv(k) + 8'h1;
    endfunction
    task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
        awaddr <= {2'b00, idx, 2'b00};
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do @(posedge clock); while (awready !== 1'b1);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        repeat (2) @(posedge clock); // stall so the response must hold
        bready <= 1'b1;
        do @(posedge clock); while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk(bresp, er);
    endtask
    task automatic rd(input logic [7:0] idx, input logic [31:0] exp, input logic [1:0] er);
        araddr <= {2'b00, idx, 2'b00};
        arvalid <= 1'b1;
        do @(posedge clock); while (arready !== 1'b1);
        arvalid <= 1'b0;
        @(posedge clock);
        rready <= 1'b1;
        do @(posedge clock); while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk({rresp, rdata}, {er, exp});
    endtask
    task automatic t_reset;
        for (int k = 0; k < 6; k++)
        begin
            rd(drv(k), 32'h0, gpm_pkg::RESP_OKAY);
            rd(sns(k), 32'h0, gpm_pkg::RESP_OKAY);
        end
        rd(gpm_pkg::IDX_PIN_FN, 32'h0, gpm_pkg::RESP_OKAY);
        rd(8'h10, 32'h0, gpm_pkg::RESP_SLVERR);
        wr(8'h10, 8'hff, gpm_pkg::RESP_SLVERR);
        chk(pOe, 45'h3c00);
    endtask
    task automatic t_gpio;
        wr(gpm_pkg::IDX_PIN_FN, 8'hff, gpm_pkg::RESP_OKAY);
        for (int k = 0; k < 6; k++)
        begin
            wr(drv(k), (k == 4) ? 8'h1f : 8'hff, gpm_pkg::RESP_OKAY);
            wr(sns(k), 8'hff, gpm_pkg::RESP_OKAY);
            wr(sns(k) + 8'h1, 8'ha5 ^ 8'(k), gpm_pkg::RESP_OKAY);
        end
        chk(pOut, {8'ha0, 5'h01, 8'ha6, 8'ha7, 8'ha4, 8'ha5});
        chk(pOe, {45{1'b1}});
        for (int k = 0; k < 6; k++)
            rd(sns(k) + 8'h1, (k == 4) ? 32'h1 : {24'h0, 8'ha5 ^ 8'(k)}, 2'h0);
        rd(sns(4), 32'h1f, gpm_pkg::RESP_OKAY);
        wr(drv(0), 8'h00, gpm_pkg::RESP_OKAY);
        extOe[7:0] <= 8'hff;
        extVal[7:0] <= 8'h3c;
        chk(padAOe, 8'h00);
        rd(sns(0) + 8'h1, 32'h3c, gpm_pkg::RESP_OKAY);
        wr(sns(0), 8'h00, gpm_pkg::RESP_OKAY);
        rd(sns(0) + 8'h1, 32'ha5, gpm_pkg::RESP_OKAY);
        extOe <= '0;
    endtask
    task automatic t_mux;
        wr(gpm_pkg::IDX_PIN_FN, 8'h00, gpm_pkg::RESP_OKAY);
        {dataBusOe, dataBusOut, debugOe, debugOut} <= {1'b1, 8'h5a, 5'h1f, 5'b10110};
        {commandLatch, addressLatch, memoryWriteStrobeN, memoryReadStrobeN} <= 4'b1010;
        {pwmEnable, pwmOut} <= 2'b11;
        {extOe[15:14], extVal[15:14]} <= 4'b1101;
        repeat (3) @(posedge clock);
        chk({padDOe, padDOut}, 16'hff5a);
        chk({padBOe[7:6], padBOut[5:2], padBOe[5:2]}, 10'b00_1010_1111);
        chk({flashReadyBusySecondN, flashReadyBusyFirstN}, 2'b01);
        chk({padAOut[4:3], padAOut[1], padCOut[1:0], padAOe}, 13'b11011_00011010);
        chk(debugIn, 5'b11110);
        pwmEnable <= 1'b0;
        repeat (3) @(posedge clock);
        chk(padCOut[0], 1'b0);
        {dataBusOe, debugOe, extOe} <= '0;
        wr(gpm_pkg::IDX_PIN_FN, 8'hff, gpm_pkg::RESP_OKAY);
    endtask
    task automatic t_osc;
        {slowOscillatorClock, fastOscillatorClock} <= 2'b10;
        wr(drv(4), 8'h80, gpm_pkg::RESP_OKAY);
        repeat (2) @(posedge clock);
        chk({padEOe[4], padEOut[4]}, 2'b11);
        wr(drv(4), 8'hc0, gpm_pkg::RESP_OKAY);
        repeat (2) @(posedge clock);
        chk({padEOe[4], padEOut[4]}, 2'b10);
        fastOscillatorClock <= 1'b1;
        repeat (3) @(posedge clock);
        chk({padEOe[4], padEOut[4]}, 2'b11);
        rd(drv(4), 32'hc0, gpm_pkg::RESP_OKAY);
    endtask
    initial
    begin
        repeat (12) @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
        t_reset();
        t_gpio();
        t_mux();
        t_osc();
        finish_test();
    end
    // whole run is well under a thousand cycles
    initial
    begin
        repeat (6000) @(posedge clock);
        error_cnt++;
        finish_test();
    end
endmodule // tb_top
